/* afc_cop.sv */
// Purpose: fabric coprocessor end of the handshake, registered responses
// Assumes: link clock arrives from the controller and is sampled on clock_i
// Notes: user logic computes result and store data from the exec outputs
`timescale 1ns/10ps
`include "afc_defines.svh"
module afc_cop (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Execution toward user logic
  output logic exec_valid_o,
  output logic [31:0] exec_instr_o,
  output logic [2:0] exec_user_num_o,
  output logic exec_load_o,
  output logic [31:0] exec_opa_o,
  output logic [31:0] exec_opb_o,
  output logic [127:0] exec_ld_data_o,
  output logic [3:0] exec_ld_off_o,
  // Results from user logic
  input wire logic [31:0] calc_result_i,
  input wire logic [127:0] calc_store_i,
  // Link
  afc_link_if.cop link
);
  import afc_pkg::*;

  typedef struct packed {
    logic ls1;
    logic ls2;
    logic ls3;
    afc_cop_st_t st;
    logic nonauton;
    logic store;
    logic ev;
    logic load;
    logic [31:0] instr;
    logic [2:0] user_num;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [127:0] ldd;
    logic [3:0] ldo;
    logic done;
    logic rv;
    logic [31:0] res;
    logic [127:0] sdata;
  } afc_cop_state_t;

  afc_cop_state_t q;
  afc_cop_state_t d;
  logic edge_s;
  logic go;

  always_comb begin
    d = q;
    d.ls1 = link.link_clk;
    d.ls2 = q.ls1;
    d.ls3 = q.ls2;
    d.ev = 1'b0;
    edge_s = q.ls2 && !q.ls3;
    go = link.writeback_permit || link.dec_store_flag; // RULE_16 RULE_18
    if (edge_s) begin
      d.done = 1'b0; // RULE_03
      d.rv = 1'b0;
      unique case (q.st)
        AFC_P_IDLE, AFC_P_WAIT: begin
          if (link.instr_issue && !link.instr_flush) begin
            d.instr = link.instr_word;
            d.user_num = link.user_instr_number;
            d.nonauton = link.dec_nonautonomous_flag;
            d.store = link.dec_store_flag;
            d.load = link.dec_load_flag;
            d.st = AFC_P_WAIT;
            if (go) begin
              d.opa = link.operand_a;
              d.opb = link.operand_b;
              d.ldd = link.load_data_bus;
              d.ldo = link.load_byte_offset;
              d.ev = 1'b1;
              d.st = AFC_P_RESP; // RULE_06
            end
          end else begin
            d.st = AFC_P_IDLE;
          end
        end
        AFC_P_RESP: begin
          if (q.nonauton && !q.store) begin
            d.rv = 1'b1; // RULE_14
            d.res = calc_result_i;
            d.st = AFC_P_CMPL;
          end else begin
            d.done = 1'b1; // RULE_06 RULE_18
            d.rv = q.store;
            d.sdata = calc_store_i;
            d.st = AFC_P_IDLE;
          end
        end
        AFC_P_CMPL: begin
          d.done = 1'b1; // RULE_14
          d.st = AFC_P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q <= '0; // RULE_21
    end else begin
      q <= d;
    end
  end

  assign exec_valid_o = q.ev;
  assign exec_instr_o = q.instr;
  assign exec_user_num_o = q.user_num;
  assign exec_load_o = q.load;
  assign exec_opa_o = q.opa;
  assign exec_opb_o = q.opb;
  assign exec_ld_data_o = q.ldd;
  assign exec_ld_off_o = q.ldo;
  assign link.copro_complete = q.done;
  assign link.copro_result_valid = q.rv;
  assign link.copro_result = q.res;
  assign link.copro_store_data = q.sdata;
endmodule

/* afc_ctrl.sv */
// Purpose: instruction controller end of the coprocessor handshake
// Assumes: clock_i at 125 MHz; coprocessor logic runs on clock_i too
// Notes: link clock is clock_i divided by 8; link steps on the divider wrap
`timescale 1ns/10ps
`include "afc_defines.svh"
module afc_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Instruction push
  input wire logic push_valid_i,
  output logic push_ready_o,
  input wire logic [31:0] push_instr_i,
  input wire logic [2:0] push_user_num_i,
  input wire logic push_nonauton_i,
  input wire logic push_load_i,
  input wire logic push_store_i,
  input wire logic push_flush_i,
  input wire logic [2:0] push_size_i,
  input wire logic [31:0] push_opa_i,
  input wire logic [31:0] push_opb_i,
  // Load data from processor
  input wire logic ld_valid_i,
  input wire logic [127:0] ld_data_i,
  input wire logic [3:0] ld_off_i,
  // Completion toward processor
  output logic cmpl_o,
  output logic res_valid_o,
  output logic [31:0] res_data_o,
  output logic [127:0] store_data_o,
  // Link
  afc_link_if.ctrl link
);
  import afc_pkg::*;

  typedef struct packed {
    logic [2:0] div;
    logic lclk;
    afc_ctrl_st_t st;
    afc_entry_t [`AFC_QDEPTH-1:0] ent;
    logic issue;
    afc_entry_t cur;
    logic ldv;
    logic wb;
    logic flush;
    logic nir;
    logic cmpl;
    logic rv;
    logic [31:0] res;
    logic [127:0] sdata;
  } afc_ctrl_state_t;

  afc_ctrl_state_t q;
  afc_ctrl_state_t d;
  logic pop;
  logic ldhit;
  logic [1:0] cnt;
  afc_entry_t nent;

  always_comb begin
    d = q;
    pop = 1'b0;
    ldhit = 1'b0;
    cnt = `AFC_CNT_ZERO;
    nent = '0;
    d.cmpl = 1'b0;
    d.rv = 1'b0;
    if (q.div == `AFC_DIV_HALF) begin
      d.lclk = 1'b0;
    end
    if (q.div == `AFC_DIV_LAST) begin
      d.div = `AFC_DIV_ZERO;
      d.lclk = 1'b1;
      d.wb = 1'b0;
      d.flush = 1'b0;
      d.ldv = 1'b0;
      d.nir = 1'b0;
      unique case (q.st)
        AFC_C_IDLE: begin
          if (q.ent[0].vld) begin
            d.issue = 1'b1; // RULE_05
            d.cur = q.ent[0]; // RULE_10 RULE_13 RULE_17
            d.st = AFC_C_OPER;
          end
        end
        AFC_C_OPER: begin
          if (q.ent[0].rdy) begin
            d.cur = q.ent[0];
            d.ldv = q.ent[0].load; // RULE_11 RULE_20
            d.flush = q.ent[0].flush; // RULE_02
            d.wb = !q.ent[0].flush && !q.ent[0].store; // RULE_05 RULE_16
            d.st = AFC_C_EXEC;
          end
        end
        AFC_C_EXEC: begin
          d.ldv = q.ldv;
          d.nir = q.ent[1].vld && q.ent[1].rdy; // RULE_08
          if (link.copro_complete || q.flush) begin
            pop = 1'b1; // RULE_01
            d.cmpl = !q.flush;
            d.nir = 1'b0;
            if (link.copro_result_valid) begin
              d.rv = 1'b1;
              d.res = link.copro_result;
              d.sdata = link.copro_store_data;
            end
            if (q.ent[1].vld && q.ent[1].rdy && q.nir) begin
              d.cur = q.ent[1]; // RULE_08 RULE_04 RULE_12 RULE_19
              d.ldv = q.ent[1].load;
              d.flush = q.ent[1].flush;
              d.wb = !q.ent[1].flush && !q.ent[1].store;
            end else if (q.ent[1].vld) begin
              d.cur = q.ent[1];
              d.ldv = 1'b0;
              d.st = AFC_C_OPER;
            end else begin
              d.issue = 1'b0;
              d.ldv = 1'b0;
              d.st = AFC_C_IDLE;
            end
          end else if (link.copro_result_valid) begin
            d.rv = 1'b1; // RULE_14
            d.res = link.copro_result;
          end
        end
        default: begin
          d.issue = 1'b0;
          d.st = AFC_C_IDLE;
        end
      endcase
    end else begin
      d.div = q.div + 3'h1;
    end
    // Queue shift, load fill and push
    if (pop) begin
      for (int i = 0; i < `AFC_QDEPTH - 1; i++) begin
        d.ent[i] = q.ent[i+1];
      end
      d.ent[`AFC_QDEPTH-1] = '0;
    end
    for (int i = 0; i < `AFC_QDEPTH; i++) begin
      if (ld_valid_i && !ldhit && d.ent[i].vld && d.ent[i].load && !d.ent[i].rdy) begin
        ldhit = 1'b1;
        d.ent[i].rdy = 1'b1; // RULE_11
        d.ent[i].ld_data = ld_data_i;
        d.ent[i].ld_off = ld_off_i;
      end
      if (d.ent[i].vld) begin
        cnt = cnt + 2'h1;
      end
    end
    nent.vld = 1'b1;
    nent.rdy = !push_load_i;
    nent.flush = push_flush_i;
    nent.nonauton = push_nonauton_i || push_store_i; // RULE_16
    nent.load = push_load_i;
    nent.store = push_store_i;
    nent.size = push_size_i;
    nent.user_num = push_user_num_i;
    nent.instr = push_instr_i;
    nent.opa = push_opa_i;
    nent.opb = push_opb_i;
    if (push_valid_i && push_ready_o) begin
      d.ent[cnt] = nent; // RULE_07
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q <= '0; // RULE_21
    end else begin
      q <= d;
    end
  end

  assign push_ready_o = !q.ent[`AFC_QDEPTH-1].vld; // RULE_07
  assign cmpl_o = q.cmpl;
  assign res_valid_o = q.rv;
  assign res_data_o = q.res;
  assign store_data_o = q.sdata;
  assign link.link_clk = q.lclk;
  assign link.instr_issue = q.issue;
  assign link.instr_word = q.cur.instr;
  assign link.user_instr_number = q.cur.user_num;
  assign link.dec_load_flag = q.issue && q.cur.load;
  assign link.dec_store_flag = q.issue && q.cur.store;
  assign link.dec_nonautonomous_flag = q.issue && q.cur.nonauton;
  assign link.ldst_transfer_size = q.cur.size;
  assign link.operand_a = q.cur.opa;
  assign link.operand_b = q.cur.opb;
  assign link.load_data_bus = q.cur.ld_data;
  assign link.load_data_valid = q.ldv;
  assign link.load_byte_offset = q.cur.ld_off;
  assign link.writeback_permit = q.wb;
  assign link.instr_flush = q.flush;
  assign link.next_instr_ready = q.nir;
endmodule

/* afc_defines.svh */
// Purpose: constants of the coprocessor instruction handshake
// Assumes: both ends share clock_i; the controller divides it into the link clock
// Notes: link clock ratio is AFC_DIV_LAST + 1, eight processor cycles per coprocessor cycle
//
// Notes on behaviour
// RULE_01: Instruction and data held until completion sampled
// RULE_02: One writeback or flush pulse per instruction; the controller gives unflushed stores neither
// RULE_03: Coprocessor responses last one link cycle
// RULE_04: Autonomous back-to-back needs 3:1 or 2:1
// RULE_05: Issue first, operands and writeback next cycle
// RULE_06: Registered coprocessor completes cycle after operands
// RULE_07: Controller buffers up to three instructions
// RULE_08: Next-ready flagged; next instruction follows completion
// RULE_09: Combinational coprocessor may complete same cycle
// RULE_10: Loads issue with load flag and size
// RULE_11: Load data forwarded with byte offset
// RULE_12: Quadword load throughput depends on ratio
// RULE_13: Non-autonomous flag issued with instruction
// RULE_14: Registered early confirm: result, then completion
// RULE_15: Combinational early confirm: result same cycle
// RULE_16: Stores are non-autonomous with early confirm; the coprocessor here raises store valid together with completion instead
// RULE_17: Store issues with store, size, non-autonomous flags
// RULE_18: Registered store returns data, valid, completion
// RULE_19: Combinational store response allows one per cycle
// RULE_20: Load data bus qualified by valid
// RULE_21: All handshake outputs low after reset
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

`define AFC_DIV_LAST 3'h7
`define AFC_DIV_HALF 3'h3
`define AFC_DIV_ZERO 3'h0
`define AFC_QDEPTH 3
`define AFC_CNT_ZERO 2'h0

`endif

/* afc_handshake_tb_top.sv */
// Purpose: bench joining controller and coprocessor over the link
// Assumes: clock_i 8 ns; link runs at one eighth of it
// Notes: word bits 13:12 give the kind: autonomous, result, load, store
`timescale 1ns/10ps
module afc_handshake_tb_top;
  import afc_pkg::*;
  typedef struct packed {
    logic [31:0] word;
    logic [31:0] opa;
    logic [31:0] opb;
  } afc_row_t;
  localparam logic [31:0] FLW = 32'h0000_0F0F;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic push_valid_i = 1'b0;
  logic push_nonauton_i = 1'b0, push_load_i = 1'b0, push_store_i = 1'b0, push_flush_i = 1'b0;
  logic [31:0] push_instr_i = 32'h0, push_opa_i = 32'h0, push_opb_i = 32'h0;
  logic [2:0] push_user_num_i = 3'h0, push_size_i = 3'h0, exec_user_num_o;
  logic ld_valid_i = 1'b0;
  logic [127:0] ld_data_i = 128'h0, calc_store_i = 128'h0, store_data_o, exec_ld_data_o;
  logic [3:0] ld_off_i = 4'h0, exec_ld_off_o;
  logic [31:0] calc_result_i = 32'h0, res_data_o, exec_instr_o, exec_opa_o, exec_opb_o;
  logic push_ready_o, cmpl_o, res_valid_o, exec_valid_o, exec_load_o;
  logic saw_flush = 1'b0;
  int miscompares = 0, checks_done = 0, ncmpl = 0;
  afc_row_t exq[$], resq[$];
  afc_row_t rows [8] = '{
    '{32'h0000_0101, 32'h11, 32'h22}, '{32'h0000_0202, 32'h33, 32'h44},
    '{32'h0000_1303, 32'hA5A5, 32'h0F0F}, '{32'h0000_2404, 32'h0, 32'h0},
    '{32'h0000_2505, 32'h0, 32'h0}, '{32'h0000_3606, 32'h1, 32'h2},
    '{32'h0000_3707, 32'h3, 32'h4}, '{32'h0000_1F00, 32'hFFFF_FFFF, 32'h1}};
  afc_link_if link ();
  afc_ctrl afc_ctrl_inst (.clock_i, .rst_n_i, .push_valid_i, .push_ready_o, .push_instr_i,
    .push_user_num_i, .push_nonauton_i, .push_load_i, .push_store_i, .push_flush_i, .push_size_i,
    .push_opa_i, .push_opb_i, .ld_valid_i, .ld_data_i, .ld_off_i, .cmpl_o, .res_valid_o,
    .res_data_o, .store_data_o, .link(link.ctrl));
  afc_cop afc_cop_inst (.clock_i, .rst_n_i, .exec_valid_o, .exec_instr_o, .exec_user_num_o,
    .exec_load_o, .exec_opa_o, .exec_opb_o, .exec_ld_data_o, .exec_ld_off_o, .calc_result_i,
    .calc_store_i, .link(link.cop));
  afc_link_props afc_link_props_inst (.clock_i, .rst_n_i, .instr_issue(link.instr_issue),
    .instr_word(link.instr_word), .dec_store_flag(link.dec_store_flag),
    .dec_nonautonomous_flag(link.dec_nonautonomous_flag),
    .writeback_permit(link.writeback_permit), .instr_flush(link.instr_flush),
    .next_instr_ready(link.next_instr_ready), .copro_complete(link.copro_complete),
    .copro_result_valid(link.copro_result_valid));
  always #4 clock_i = ~clock_i;
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic push(input afc_row_t r, input logic fl);
    while (push_ready_o !== 1'b1) @(negedge clock_i);
    push_valid_i = 1'b1;
    {push_instr_i, push_opa_i, push_opb_i} = r;
    push_user_num_i = r.word[2:0];
    push_nonauton_i = r.word[12];
    push_load_i = r.word[13:12] == 2'h2;
    push_store_i = r.word[13:12] == 2'h3;
    push_size_i = r.word[13] ? 3'h4 : 3'h0;
    push_flush_i = fl;
    @(negedge clock_i);
    push_valid_i = 1'b0;
    if (push_load_i) begin
      ld_valid_i = 1'b1;
      ld_data_i = {4{~r.word}};
      ld_off_i = r.word[3:0];
      @(negedge clock_i);
      ld_valid_i = 1'b0;
    end else begin
      @(negedge clock_i);
    end
    if (!fl) exq.push_back(r);
    if (!fl && r.word[12]) resq.push_back(r);
  endtask
  task automatic drain(input string name);
    for (int k = 0; k < 3000 && (exq.size() + resq.size()) > 0; k++) @(negedge clock_i);
    check(exq.size() + resq.size(), 0);
    repeat (40) @(negedge clock_i);
    $display("test %s done", name);
  endtask
  // User logic answers from what the coprocessor hands out
  always @(negedge clock_i) begin
    calc_result_i <= exec_opa_o ^ exec_opb_o;
    calc_store_i <= {4{exec_instr_o}};
  end
  always @(negedge clock_i) begin
    if (link.instr_flush === 1'b1) saw_flush = 1'b1;
    if (link.load_data_valid === 1'b1) begin
      check(link.load_data_bus, {4{~link.instr_word}});
    end
    if (link.instr_issue === 1'b1) begin
      check({link.dec_load_flag, link.dec_store_flag, link.dec_nonautonomous_flag},
        {link.instr_word[13:12] == 2'h2, link.instr_word[13:12] == 2'h3, link.instr_word[12]});
      if (link.instr_word[13]) check(link.ldst_transfer_size, 3'h4);
    end
    if (exec_valid_o === 1'b1 && exec_instr_o !== FLW && exq.size() > 0) begin
      check(exec_instr_o, exq[0].word);
      check({exec_user_num_o, exec_opa_o, exec_opb_o},
        {exq[0].word[2:0], exq[0].opa, exq[0].opb});
      check(exec_load_o, exq[0].word[13:12] == 2'h2);
      if (exec_load_o === 1'b1) begin
        check(exec_ld_data_o, {4{~exq[0].word}});
        check(exec_ld_off_o, exq[0].word[3:0]);
      end
      void'(exq.pop_front());
    end
    if (res_valid_o === 1'b1 && resq.size() > 0) begin
      if (resq[0].word[13]) check(store_data_o, {4{resq[0].word}});
      else check(res_data_o, resq[0].opa ^ resq[0].opb);
      void'(resq.pop_front());
    end
    if (cmpl_o === 1'b1) ncmpl++;
  end
  initial begin
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    foreach (rows[i]) begin
      push(rows[i], 1'b0);
      if (i == 2) check(push_ready_o, 1'b0);
    end
    drain("rows");
    check(ncmpl, 8);
    push(afc_row_t'{FLW, 32'h5, 32'h6}, 1'b1);
    push(rows[0], 1'b0);
    drain("flush");
    check({saw_flush, 32'(ncmpl)}, {1'b1, 32'd9});
    push(rows[2], 1'b0);
    repeat (20) @(negedge clock_i);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    exq.delete();
    resq.delete();
    @(negedge clock_i);
    check({link.instr_issue, link.writeback_permit, link.copro_complete,
      link.copro_result_valid, link.instr_flush, link.next_instr_ready}, 6'h0);
    ncmpl = 0;
    push(rows[5], 1'b0);
    drain("reset");
    check(ncmpl, 1);
    summarize();
  end
  // Whole run needs well under a thousand cycles; allow over twenty times that
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    summarize();
  end
endmodule

/* afc_link_if.sv */
// Purpose: link between instruction controller and fabric coprocessor
// Assumes: ctrl drives the link clock
// Notes: no tristate pins
`timescale 1ns/10ps
interface afc_link_if;
  logic link_clk;
  logic instr_issue;
  logic [31:0] instr_word;
  logic [2:0] user_instr_number;
  logic dec_load_flag;
  logic dec_store_flag;
  logic dec_nonautonomous_flag;
  logic [2:0] ldst_transfer_size;
  logic [31:0] operand_a;
  logic [31:0] operand_b;
  logic [127:0] load_data_bus;
  logic load_data_valid;
  logic [3:0] load_byte_offset;
  logic writeback_permit;
  logic instr_flush;
  logic next_instr_ready;
  logic copro_complete;
  logic copro_result_valid;
  logic [31:0] copro_result;
  logic [127:0] copro_store_data;

  modport ctrl (
    output link_clk, instr_issue, instr_word, user_instr_number, dec_load_flag,
    output dec_store_flag, dec_nonautonomous_flag, ldst_transfer_size, operand_a,
    output operand_b, load_data_bus, load_data_valid, load_byte_offset,
    output writeback_permit, instr_flush, next_instr_ready,
    input copro_complete, copro_result_valid, copro_result, copro_store_data
  );

  modport cop (
    input link_clk, instr_issue, instr_word, user_instr_number, dec_load_flag,
    input dec_store_flag, dec_nonautonomous_flag, ldst_transfer_size, operand_a,
    input operand_b, load_data_bus, load_data_valid, load_byte_offset,
    input writeback_permit, instr_flush, next_instr_ready,
    output copro_complete, copro_result_valid, copro_result, copro_store_data
  );
endinterface

/* afc_link_properties.sv */
// Purpose: link checks between controller and coprocessor
// Assumes: one clock domain; link stepped every eight clock_i cycles
// Notes: instantiated beside the link interface
`timescale 1ns/10ps
module afc_link_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Link signals
  input wire logic instr_issue,
  input wire logic [31:0] instr_word,
  input wire logic dec_store_flag,
  input wire logic dec_nonautonomous_flag,
  input wire logic writeback_permit,
  input wire logic instr_flush,
  input wire logic next_instr_ready,
  input wire logic copro_complete,
  input wire logic copro_result_valid
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  hold_instr_a: assert property (
    instr_issue && !copro_complete && !instr_flush |=> $stable(instr_word))
    else $error("instruction moved before completion");
  wb_pulse_a: assert property ($rose(writeback_permit) |->
    writeback_permit [*8] ##1 !writeback_permit) else $error("writeback pulse length");
  wb_flush_excl_a: assert property (
    !(writeback_permit && instr_flush)) else $error("writeback and flush together");
  done_pulse_a: assert property ($rose(copro_complete) |->
    copro_complete [*8] ##1 !copro_complete) else $error("completion pulse length");
  rv_pulse_a: assert property ($rose(copro_result_valid) |=>
    $stable(copro_result_valid) [*7] ##1 $fell(copro_result_valid))
    else $error("result valid pulse length");
  ops_follow_a: assert property (
    $rose(writeback_permit) |-> $past(instr_issue, 8)) else $error("operands before issue");
  auton_done_a: assert property (
    $rose(writeback_permit) && !dec_nonautonomous_flag |-> ##[9:13] $rose(copro_complete))
    else $error("autonomous completion late");
  early_conf_a: assert property (
    $rose(writeback_permit) && dec_nonautonomous_flag |->
    ##[9:13] $rose(copro_result_valid) ##8 $rose(copro_complete)) else $error("result order");
  store_pair_a: assert property (
    $rose(copro_complete) |-> copro_result_valid == dec_store_flag) else $error("store reply");
  store_flag_a: assert property (
    instr_issue && dec_store_flag |-> dec_nonautonomous_flag) else $error("store flags");
  nir_direct_a: assert property (
    $fell(next_instr_ready) |->
    instr_issue && (writeback_permit || instr_flush || dec_store_flag))
    else $error("next instruction not presented after completion");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n_i |=> !(instr_issue |
    writeback_permit | instr_flush | next_instr_ready | copro_complete | copro_result_valid))
    else $error("handshake active after reset");
  cover property ($rose(copro_complete) && dec_store_flag);
  cover property ($rose(copro_result_valid) && !dec_store_flag);
  cover property ($rose(instr_flush));
  cover property (next_instr_ready && copro_complete);
endmodule

/* afc_pkg.sv */
// Purpose: types of the coprocessor instruction handshake
// Assumes: none
// Notes: queue entry layout shared by the controller
package afc_pkg;

  typedef struct packed {
    logic vld;
    logic rdy;
    logic flush;
    logic nonauton;
    logic load;
    logic store;
    logic [2:0] size;
    logic [2:0] user_num;
    logic [31:0] instr;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [127:0] ld_data;
    logic [3:0] ld_off;
  } afc_entry_t;

  typedef enum logic [1:0] {
    AFC_C_IDLE = 2'h0,
    AFC_C_OPER = 2'h1,
    AFC_C_EXEC = 2'h3
  } afc_ctrl_st_t;

  typedef enum logic [1:0] {
    AFC_P_IDLE = 2'h0,
    AFC_P_WAIT = 2'h1,
    AFC_P_RESP = 2'h3,
    AFC_P_CMPL = 2'h2
  } afc_cop_st_t;

endpackage
